// ---- src/tsr_core.sv ----
// temperature sensor digital core: registers, conversion scheduling, alert
// Functional notes
// R01: pointer is eight bits, only two writable
// R02: pointer selects result, setup, lower, upper
// R03: result read-only; setup and thresholds read-write
// R04: sixteen-bit words move upper byte first
// R05: setup bits 0-4, 13-14 ignore writes
// R06: host keeps word width bit at zero
// R07: flag flips after N highs, back after N lows
// R08: level select inverts flag sense
// R09: comparator mode flag equals alert pin
// R10: rate bits give 4s, 1s, 250ms, 125ms
// R11: rate resets to 250ms
// R12: result changes only when conversion completes
// R13: conversion starts at once after reset
// R14: standby between conversions until timer fires
// R15: sleep stops conversion at once
// R16: registers stay accessible while asleep
// R17: clearing sleep resumes periodic conversions
// R18: notify bit picks comparator or interrupt
// R19: comparator alert holds until below lower
// R20: interrupt alert fires on each crossing
// R21: level select gives low or high alert
// R22: fault field needs 1, 2, 4, 6 results
// R23: interrupt alert clears on read or sleep
// R24: one-shot runs one conversion, reads busy
// R25: comparisons use signed twelve-bit values
// R26: failing result restarts the fault run
`timescale 1ns/1ps
module tsr_core
  import tsr_pkg::*;
#(
  parameter int P_MS_CYCLES = MS_CYCLES
)(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        BUS_START_I,
  input  wire logic        BUS_WR_I,
  input  wire logic [7:0]  BUS_WDATA_I,
  input  wire logic        BUS_RD_I,
  output logic [7:0]       BUS_RDATA_O,
  output logic             CONV_START_O,
  output logic             CONV_ACTIVE_O,
  input  wire logic        CONV_DONE_I,
  input  wire logic [11:0] CONV_DATA_I,
  output logic             ALERT_O
);

  // ==========================================================
  // helpers
  function automatic logic t_ge(input logic [11:0] a, input logic [11:0] b);
    t_ge = $signed(a) >= $signed(b);
  endfunction
  function automatic logic [2:0] fault_n(input logic [1:0] sel);
    fault_n = sel[1] ? (sel[0] ? FAULT_N3 : FAULT_N2) : (sel[0] ? FAULT_N1 : FAULT_N0);
  endfunction
  function automatic logic [12:0] ivl_ms(input logic [1:0] sel);
    ivl_ms = sel[1] ? (sel[0] ? IVL_125_MS : IVL_250_MS) : (sel[0] ? IVL_1S_MS : IVL_4S_MS);
  endfunction

  // ==========================================================
  // registers and state
  logic [1:0]  ptr_ff, fault_sel_ff, rate_ff;
  logic        ptr_due_ff, lsb_ff, oneshot_ff, pol_ff, notify_ff, sleep_ff;
  logic        tripped_ff, irq_ff, kick_ff;
  logic [7:0]  msb_hold_ff, rdata_ff;
  logic [11:0] result_ff, lower_ff, upper_ff;
  logic [2:0]  run_ff;
  logic [31:0] div_ff;
  logic [12:0] ms_cnt_ff;
  tsr_state_t  state_ff, nxt_state;
  // decoded strobes and combinational values
  logic        data_wr, word_wr, setup_wr, sleep_entry, flag, ms_tick;
  logic        start, abort, accept, qual, toggle;
  logic [15:0] wword, setup_rd, sel_word;

  // ==========================================================
  // byte port: pointer byte after start, then upper then lower byte
  assign data_wr     = BUS_WR_I && !ptr_due_ff;
  assign word_wr     = data_wr && lsb_ff;                        // [R04]
  assign wword       = {msb_hold_ff, BUS_WDATA_I};
  assign setup_wr    = word_wr && (ptr_ff == PTR_SETUP);
  assign sleep_entry = setup_wr && wword[SET_SLEEP] && !sleep_ff;

  // pointer keeps only its two low bits; upper bits are dropped
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ptr_ff     <= PTR_RESULT;
      ptr_due_ff <= 1'b0;
    end
    else if (BUS_START_I)
      ptr_due_ff <= 1'b1;
    else if (BUS_WR_I && ptr_due_ff)
    begin
      ptr_ff     <= BUS_WDATA_I[1:0];                            // [R01] [R02]
      ptr_due_ff <= 1'b0;
    end
    else if (BUS_RD_I)
      ptr_due_ff <= 1'b0;
  end

  // byte phase and upper byte holding
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      lsb_ff      <= 1'b0;
      msb_hold_ff <= 8'h00;
    end
    else if (BUS_START_I || (BUS_WR_I && ptr_due_ff))
      lsb_ff <= 1'b0;
    else if (data_wr || BUS_RD_I)
    begin
      lsb_ff <= !lsb_ff;                                         // [R04]
      if (data_wr && !lsb_ff)
        msb_hold_ff <= BUS_WDATA_I;
    end
  end

  // threshold words; result register has no write path
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      lower_ff <= LOWER_RST;
      upper_ff <= UPPER_RST;
    end
    else if (word_wr && ptr_ff == PTR_LOWER)
      lower_ff <= wword[15:4];                                   // [R03]
    else if (word_wr && ptr_ff == PTR_UPPER)
      upper_ff <= wword[15:4];
  end

  // setup fields; read-only positions are never stored
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      fault_sel_ff <= 2'h0;
      pol_ff       <= 1'b0;
      notify_ff    <= 1'b0;
      sleep_ff     <= 1'b0;
      rate_ff      <= RATE_RST;                                  // [R11]
    end
    else if (setup_wr)
    begin
      fault_sel_ff <= wword[SET_FAULT_HI:SET_FAULT_LO];          // [R05] [R06]
      pol_ff       <= wword[SET_POL];
      notify_ff    <= wword[SET_NOTIFY];                         // [R18]
      sleep_ff     <= wword[SET_SLEEP];                          // [R16]
      rate_ff      <= wword[SET_RATE_HI:SET_RATE_LO];
    end
  end

  // one-shot: armed by a write while asleep, busy until the result lands
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      oneshot_ff <= 1'b0;
    else if (setup_wr && wword[SET_ONESHOT] && sleep_ff && wword[SET_SLEEP])
      oneshot_ff <= 1'b1;                                        // [R24]
    else if (accept || (setup_wr && !wword[SET_SLEEP]))
      oneshot_ff <= 1'b0;
  end

  // ==========================================================
  // read path: registered byte of the selected word
  assign flag     = pol_ff ? tripped_ff : !tripped_ff;           // [R07] [R08]
  assign setup_rd = {oneshot_ff, SET_RSVD_VAL, fault_sel_ff, pol_ff, notify_ff,
                     sleep_ff, rate_ff, flag, 5'h00};            // [R05]

  always_comb
  begin
    case (ptr_ff)
      PTR_RESULT: sel_word = {result_ff, 4'h0};
      PTR_SETUP:  sel_word = setup_rd;
      PTR_LOWER:  sel_word = {lower_ff, 4'h0};
      default:    sel_word = {upper_ff, 4'h0};
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rdata_ff <= 8'h00;
    else if (BUS_RD_I)
      rdata_ff <= lsb_ff ? sel_word[7:0] : sel_word[15:8];       // [R04]
  end
  assign BUS_RDATA_O = rdata_ff;

  // ==========================================================
  // conversion scheduling on a millisecond enable
  assign ms_tick = (div_ff == 32'(P_MS_CYCLES - 1));

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      div_ff <= 32'h0;
    else if (ms_tick)
      div_ff <= 32'h0;
    else
      div_ff <= div_ff + 32'h1;
  end

  // interval counted from each conversion start
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ms_cnt_ff <= 13'h0;
    else if (start)
      ms_cnt_ff <= 13'h0;
    else if (ms_tick && ms_cnt_ff != 13'h1FFF)
      ms_cnt_ff <= ms_cnt_ff + 13'h1;
  end

  // immediate start after reset and after sleep is cleared
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      kick_ff <= 1'b1;                                           // [R13]
    else if (setup_wr && sleep_ff && !wword[SET_SLEEP])
      kick_ff <= 1'b1;                                           // [R17]
    else if (start)
      kick_ff <= 1'b0;
  end

  assign start  = (state_ff == ST_STANDBY) && !sleep_entry &&
                  ((!sleep_ff && (kick_ff || ms_cnt_ff >= ivl_ms(rate_ff))) ||
                   (sleep_ff && oneshot_ff));                    // [R10] [R14] [R24]
  assign abort  = (state_ff == ST_CONVERT) && sleep_ff && !oneshot_ff;
  assign accept = (state_ff == ST_CONVERT) && CONV_DONE_I && !abort && !sleep_entry;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_STANDBY: if (start) nxt_state = ST_CONVERT;
      ST_CONVERT: if (accept || abort || sleep_entry) nxt_state = ST_STANDBY; // [R15]
      default:    nxt_state = ST_STANDBY;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      state_ff <= ST_STANDBY;
    else
      state_ff <= nxt_state;
  end
  assign CONV_START_O  = start;
  assign CONV_ACTIVE_O = (state_ff == ST_CONVERT);

  // result updates only on an accepted conversion
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      result_ff <= RESULT_RST;
    else if (accept)
      result_ff <= CONV_DATA_I;                                  // [R12]
  end

  // ==========================================================
  // threshold evaluation with consecutive-result filter
  assign qual   = tripped_ff ? t_ge(lower_ff, CONV_DATA_I)
                             : t_ge(CONV_DATA_I, upper_ff);      // [R25]
  assign toggle = accept && qual && ({1'b0, run_ff} + 4'h1 >= {1'b0, fault_n(fault_sel_ff)});

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      tripped_ff <= 1'b0;
      run_ff     <= 3'h0;
    end
    else if (accept)
    begin
      if (toggle)
      begin
        tripped_ff <= !tripped_ff;                               // [R19] [R22]
        run_ff     <= 3'h0;
      end
      else if (qual)
        run_ff <= run_ff + 3'h1;
      else
        run_ff <= 3'h0;                                          // [R26]
    end
  end

  // interrupt latch: set by each crossing, set wins over clear
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      irq_ff <= 1'b0;
    else if (!notify_ff)
      irq_ff <= 1'b0;
    else if (toggle)
      irq_ff <= 1'b1;                                            // [R20]
    else if (BUS_RD_I || sleep_entry)
      irq_ff <= 1'b0;                                            // [R23]
  end

  // alert pin level from mode and polarity
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ALERT_O <= 1'b1;
    else
      ALERT_O <= (notify_ff ? irq_ff : tripped_ff) ~^ pol_ff;    // [R09] [R21]
  end

  // ==========================================================
  // checks
  a_flag_pin_match: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R09]
    (!notify_ff && $stable(notify_ff) && $stable(tripped_ff) && $stable(pol_ff))
      |-> ALERT_O == flag) else $error("flag and alert pin differ");
  a_result_on_done: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R12]
    !$stable(result_ff) |-> $past(accept)) else $error("result moved without a done");
  a_sleep_stops: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R15]
    sleep_entry |=> !CONV_ACTIVE_O) else $error("conversion ran on after sleep");
  a_start_cause: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R10]
    (CONV_START_O && !sleep_ff && !kick_ff) |-> ms_cnt_ff >= ivl_ms(rate_ff))
    else $error("conversion started before the interval");
  a_irq_read_clear: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R23]
    (notify_ff && irq_ff && BUS_RD_I && !toggle) |=> !irq_ff)
    else $error("interrupt alert survived a read");
  a_fault_run: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R22]
    $changed(tripped_ff) |-> ($past(run_ff) + 3'h1 >= $past(fault_n(fault_sel_ff))))
    else $error("flag changed before the fault count");
  a_oneshot_busy: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R24]
    (oneshot_ff && CONV_ACTIVE_O && !accept && !setup_wr) |=> oneshot_ff)
    else $error("one-shot bit cleared early");
  a_setup_fixed: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R05]
    (BUS_RD_I && ptr_ff == PTR_SETUP && !lsb_ff) |=> BUS_RDATA_O[6:5] == SET_RSVD_VAL)
    else $error("reserved setup bits read wrong");
  a_fail_resets: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [R26]
    (accept && !qual) |=> run_ff == 3'h0) else $error("fault run not restarted");
endmodule

// ---- src/tsr_pkg.sv ----
// package: register map, setup field layout, reset values and timing counts
package tsr_pkg;
  // pointer values
  localparam logic [1:0]  PTR_RESULT    = 2'h0;
  localparam logic [1:0]  PTR_SETUP     = 2'h1;
  localparam logic [1:0]  PTR_LOWER     = 2'h2;
  localparam logic [1:0]  PTR_UPPER     = 2'h3;
  // setup field positions
  localparam int          SET_ONESHOT   = 15;
  localparam int          SET_FAULT_HI  = 12;
  localparam int          SET_FAULT_LO  = 11;
  localparam int          SET_POL       = 10;
  localparam int          SET_NOTIFY    = 9;
  localparam int          SET_SLEEP     = 8;
  localparam int          SET_RATE_HI   = 7;
  localparam int          SET_RATE_LO   = 6;
  localparam int          SET_FLAG      = 5;
  // fixed read-only upper reserved pair (bits 14:13)
  localparam logic [1:0]  SET_RSVD_VAL  = 2'h2;
  // reset values
  localparam logic [1:0]  RATE_RST      = 2'h2;
  localparam logic [11:0] LOWER_RST     = 12'h4B0;
  localparam logic [11:0] UPPER_RST     = 12'h500;
  localparam logic [11:0] RESULT_RST    = 12'h000;
  // timing: one millisecond tick derived from the core clock
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          TICK_MS_NS    = 1000000;
  localparam int          MS_CYCLES     = TICK_MS_NS / CLK_PERIOD_NS;
  // conversion intervals in milliseconds
  localparam logic [12:0] IVL_4S_MS     = 13'h0FA0;
  localparam logic [12:0] IVL_1S_MS     = 13'h03E8;
  localparam logic [12:0] IVL_250_MS    = 13'h00FA;
  localparam logic [12:0] IVL_125_MS    = 13'h007D;
  // consecutive fault counts
  localparam logic [2:0]  FAULT_N0      = 3'h1;
  localparam logic [2:0]  FAULT_N1      = 3'h2;
  localparam logic [2:0]  FAULT_N2      = 3'h4;
  localparam logic [2:0]  FAULT_N3      = 3'h6;
  // conversion sequencer states
  typedef enum logic [0:0] {
    ST_STANDBY = 1'b0,
    ST_CONVERT = 1'b1
  } tsr_state_t;
endpackage

// ---- tb/test_tsr_core.sv ----
// testbench: register access, conversion timing and alert behaviour
`timescale 1ns/1ps
module test_tsr_core;
  import tsr_pkg::*;
  localparam int P_MS = 4;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        st = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        cs, ca, done, alert;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  rdat;
  logic [11:0] cdata;
  logic [11:0] temp;
  logic [15:0] v, w;
  int          fails = 0;
  int          samples_checked = 0;
  int          seed, n;
  int          ivl [4] = '{4000, 1000, 250, 125};
  int          nf [4] = '{1, 2, 4, 6};
  time         t0;
  // free-running core clock
  always #20 clk = ~clk;
  tsr_core #(.P_MS_CYCLES(P_MS)) u_tsr_core (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .BUS_START_I(st), .BUS_WR_I(wr), .BUS_WDATA_I(wd), .BUS_RD_I(rd), .BUS_RDATA_O(rdat),
    .CONV_START_O(cs), .CONV_ACTIVE_O(ca), .CONV_DONE_I(done), .CONV_DATA_I(cdata),
    .ALERT_O(alert));
  tsr_conv_model #(.P_LAT(32 * P_MS)) u_tsr_conv_model (.clk_i(clk), .rst_n_i(rst_n), .start_i(cs),
    .active_i(ca), .temp_i(temp), .done_o(done), .data_o(cdata));
  // ==========================================
  // helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe of kind k: 0 start, 1 write byte, 2 read byte
  task automatic pulse(input int k, input logic [7:0] b);
    @(negedge clk);
    st = (k == 0);
    wr = (k == 1);
    rd = (k == 2);
    wd = b;
    @(negedge clk);
    st = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [15:0] d);
    pulse(0, 8'h00);
    pulse(1, p);
    pulse(1, d[15:8]);
    pulse(1, d[7:0]);
  endtask
  task automatic rd_reg(input logic [7:0] p, output logic [15:0] d);
    pulse(0, 8'h00);
    pulse(1, p);
    pulse(2, 8'h00);
    d[15:8] = rdat;
    pulse(2, 8'h00);
    d[7:0] = rdat;
  endtask
  // bounded wait for a start (0) or a done (1); returns cycles waited
  task automatic wait_sig(input bit use_done, output int cyc);
    cyc = 0;
    do
    begin
      @(negedge clk);
      cyc++;
      if (cyc > 20000)
      begin
        fails++;
        end_sim();
      end
    end while ((use_done ? done : cs) !== 1'b1);
  endtask
  // let k conversions finish at temperature t, then let the pin settle
  task automatic conv(input logic [11:0] t, input int k);
    int c;
    temp = t;
    repeat (k) wait_sig(1'b1, c);
    repeat (3) @(negedge clk);
  endtask
  // expected setup read: writable fields, fixed reserved pair, flag
  function automatic logic [15:0] cfg(input logic [15:0] d, input logic flag);
    cfg = (d & 16'h9FC0) | {1'b0, SET_RSVD_VAL, 13'h0000} | {10'h000, flag, 5'h00};
  endfunction
  // ==========================================
  // main sequence
  initial
  begin
    seed = 32'h95b0;
    temp = {2'b00, 10'($random(seed))}; // stays below the reset limits
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t0 = $time;
    @(negedge clk);
    chk({15'h0000, ca}, 16'h0001);
    rd_reg({6'h00, PTR_RESULT}, v);
    chk(v, 16'h0000);
    rd_reg({6'h00, PTR_SETUP}, v);
    chk(v, cfg({8'h00, RATE_RST, 6'h00}, 1'b1));
    rd_reg({6'h00, PTR_LOWER}, v);
    chk(v, {LOWER_RST, 4'h0});
    rd_reg({6'h00, PTR_UPPER}, v);
    chk(v, {UPPER_RST, 4'h0});
    wait_sig(1'b1, n);
    chk(16'(($time - t0) <= 64'(40 * P_MS * CLK_PERIOD_NS)), 16'h0001);
    rd_reg({6'h00, PTR_RESULT}, v);
    chk(v, {temp, 4'h0});
    wr_reg({6'h00, PTR_RESULT}, 16'h5A50);
    rd_reg({6'h00, PTR_RESULT}, v);
    chk(v, {temp, 4'h0});
    for (int i = 0; i < 4; i++)
    begin
      w = {2'b01, 10'($random(seed)), 4'h0}; // above any early result
      wr_reg({6'h3F, 2'(2 + i % 2)}, w);
      rd_reg({6'h00, 2'(2 + i % 2)}, v);
      chk(v, w);
    end
    wr_reg({6'h00, PTR_SETUP}, 16'h60CF); // word width bit kept at zero
    rd_reg({6'h00, PTR_SETUP}, v);
    chk(v, cfg(16'h60CF, 1'b1));
    temp = 12'hE00; // nothing qualifies while the limits move
    wr_reg({6'h00, PTR_LOWER}, 16'hF000);
    wr_reg({6'h00, PTR_UPPER}, 16'h0100);
    // comparator mode over every fault count, both polarities
    for (int f = 0; f < 4; f++)
    begin
      w = {3'h0, f[1:0], f[0], 10'h0C0};
      wr_reg({6'h00, PTR_SETUP}, w);
      conv(12'h020, nf[f] - 1);
      chk(alert, !w[10]);
      conv(12'hE00, 1);
      conv(12'h020, nf[f] - 1);
      chk(alert, !w[10]);
      conv(12'h020, 1);
      chk(alert, w[10]);
      rd_reg({6'h00, PTR_SETUP}, v);
      chk(v, cfg(w, w[10]));
      chk(alert, v[SET_FLAG]);
      conv(12'hE00, nf[f] - 1);
      chk(alert, w[10]);
      conv(12'hE00, 1);
      chk(alert, !w[10]);
    end
    // interrupt mode: each crossing, cleared by read and by sleep
    wr_reg({6'h00, PTR_SETUP}, 16'h02C0);
    conv(12'h020, 1);
    chk(alert, 1'b0);
    rd_reg({6'h00, PTR_LOWER}, v);
    repeat (2) @(negedge clk);
    chk(alert, 1'b1);
    conv(12'h020, 1);
    chk(alert, 1'b1);
    conv(12'hE00, 1);
    chk(alert, 1'b0);
    wr_reg({6'h00, PTR_SETUP}, 16'h03C0);
    repeat (2) @(negedge clk);
    chk(alert, 1'b1);
    chk(ca, 1'b0);
    n = 0;
    repeat (1000)
    begin
      @(negedge clk);
      n += cs;
    end
    chk(16'(n), 16'h0000);
    rd_reg({6'h00, PTR_UPPER}, v);
    chk(v, 16'h0100);
    // one-shot while asleep
    temp = 12'($random(seed));
    wr_reg({6'h00, PTR_SETUP}, 16'h83C0);
    rd_reg({6'h00, PTR_SETUP}, v);
    chk(v[SET_ONESHOT], 1'b1);
    chk(ca, 1'b1);
    wait_sig(1'b1, n);
    repeat (3) @(negedge clk);
    rd_reg({6'h00, PTR_SETUP}, v);
    chk(v[SET_ONESHOT], 1'b0);
    rd_reg({6'h00, PTR_RESULT}, v);
    chk(v, {temp, 4'h0});
    // wake at each rate, then time start to start
    for (int r = 0; r < 4; r++)
    begin
      wr_reg({6'h00, PTR_SETUP}, {8'h01, 2'(r), 6'h00});
      wr_reg({6'h00, PTR_SETUP}, {8'h00, 2'(r), 6'h00});
      chk({15'h0000, cs}, 16'h0001);
      wait_sig(1'b0, n);
      chk(16'(n + P_MS >= ivl[r] * P_MS && n <= ivl[r] * P_MS + 1), 16'h0001);
      wait_sig(1'b0, n);
      chk(16'(n), 16'(ivl[r] * P_MS));
    end
    end_sim();
  end
endmodule

// ---- tb/tsr_conv_model.sv ----
// converter partner: answers each start the core does not abort with one result after a fixed latency
`timescale 1ns/1ps
module tsr_conv_model #(
  parameter int P_LAT = 200
)(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic        active_i,
  input  wire logic [11:0] temp_i,
  output logic             done_o,
  output logic [11:0]      data_o
);
  int cnt;
  // count down from each start; an abort by the core drops the conversion
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= 0;
      done_o <= 1'b0;
      data_o <= 12'hA5A;
    end
    else
    begin
      done_o <= 1'b0;
      data_o <= ~data_o; // value flips every cycle outside the done cycle
      if (start_i)
        cnt <= P_LAT;
      else if (cnt == 1 && active_i)
      begin
        done_o <= 1'b1;
        data_o <= temp_i;
        cnt <= 0;
      end
      else if (cnt > 0)
        cnt <= active_i ? cnt - 1 : 0;
    end
  end
endmodule
